/* logic/mors_pkg.sv */
package mors_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Data and bus widths
    localparam int DATA_W = 32;   // Read data width of each port
    localparam int ADDR_W = 12;   // APB address width decoded
    localparam int LAT_W = 2;     // Width of a latency figure

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [11:0] CFG_OFFSET = 12'h000;    // Port option register
    localparam logic [11:0] STATUS_OFFSET = 12'h004; // Effective setup and latency

    ////////////////////////////////////////////////////////////////////////////
    // Field layout of the option register, one byte per port
    localparam int PORT_A_LSB = 0;  // Port A option byte
    localparam int PORT_B_LSB = 8;  // Port B option byte
    localparam int OPT_W = 5;       // Option bits used per port
    localparam logic [4:0] CFG_RESET = 5'h00; // All options off after reset

    // Field layout of the status register, one byte per port
    localparam int ST_LAT_LSB = 0;      // Latency in cycles within the byte
    localparam int ST_LATCH_CLR = 2;    // Latch reset really in force
    localparam int ST_A_LSB = 0;        // Port A status byte
    localparam int ST_B_LSB = 8;        // Port B status byte

    ////////////////////////////////////////////////////////////////////////////
    // Option bits of one port, high bit first
    typedef struct packed {
        logic prio_reset;  // 1: reset wins over enable, 0: enable gates reset
        logic latch_clr;   // Requested read latch clear on reset
        logic rst_use;     // Port reset input in use
        logic core_reg;    // Register at the outer output
        logic prim_reg;    // Register at the primitive output
    } mors_opt_t;

    // Inputs of one read port from user logic and the array
    typedef struct packed {
        logic en;                   // Memory enable, loads the read latch
        logic regce;                // Clock enable of output registers
        logic rst;                  // Synchronous port reset
        logic [DATA_W-1:0] mem_data; // Array word addressed this cycle
    } mors_port_in_t;

    // Pipeline state of one read port
    typedef struct packed {
        logic [DATA_W-1:0] latch;  // Read latch
        logic [DATA_W-1:0] prim;   // Primitive output register
        logic [DATA_W-1:0] core;   // Core output register
    } mors_port_st_t;

    // Whole state of the block
    typedef struct packed {
        mors_opt_t opt_a;          // Port A options
        mors_opt_t opt_b;          // Port B options
        mors_port_st_t pa;         // Port A pipeline
        mors_port_st_t pb;         // Port B pipeline
        logic [31:0] prdata;       // Read data held for the access phase
        logic pslverr;             // Error held for the access phase
    } mors_state_t;

endpackage

/* logic/mors_top.sv */
`timescale 1ns/1ps
module mors_top #(
    parameter logic [mors_pkg::DATA_W-1:0] INIT_A = 32'h0000_0000, // Port A reset value
    parameter logic [mors_pkg::DATA_W-1:0] INIT_B = 32'h0000_0000  // Port B reset value
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [mors_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire mors_pkg::mors_port_in_t port_a_in,
    input wire mors_pkg::mors_port_in_t port_b_in,
    output logic [mors_pkg::DATA_W-1:0] dout_a,
    output logic [mors_pkg::DATA_W-1:0] dout_b
);

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions, each used for both ports

    // Latch clear is only offered with primitive register, no core, reset in use
    function automatic logic latch_clr_ok(input mors_pkg::mors_opt_t o);
        latch_clr_ok = o.latch_clr & o.prim_reg & ~o.core_reg & o.rst_use;
    endfunction

    // Read latency: one latch cycle plus one per chosen stage
    function automatic logic [mors_pkg::LAT_W-1:0] port_latency(input mors_pkg::mors_opt_t o);
        port_latency = 2'h1 + {1'b0, o.prim_reg} + {1'b0, o.core_reg};
    endfunction

    // Output mux: outermost chosen stage drives the port
    function automatic logic [mors_pkg::DATA_W-1:0] port_out(
        input mors_pkg::mors_opt_t o,
        input mors_pkg::mors_port_st_t s
    );
        if (o.core_reg) begin
            port_out = s.core;
        end else if (o.prim_reg) begin
            port_out = s.prim;
        end else begin
            port_out = s.latch;
        end
    endfunction

    // Next pipeline state of one port
    function automatic mors_pkg::mors_port_st_t port_step(
        input mors_pkg::mors_opt_t o,
        input mors_pkg::mors_port_in_t i,
        input mors_pkg::mors_port_st_t s,
        input logic [mors_pkg::DATA_W-1:0] init
    );
        logic output_register_clear;
        logic read_latch_clear;
        logic no_regs;
        output_register_clear = 1'b0;
        read_latch_clear = 1'b0;
        no_regs = ~o.prim_reg & ~o.core_reg;
        port_step = s;
        // Output registers: reset gated by regce unless reset has priority
        output_register_clear = o.rst_use & i.rst & (o.prio_reset | i.regce);
        // Latch: cleared only when no registers exist or the clear option is live
        read_latch_clear = o.rst_use & i.rst & (o.prio_reset | i.en)
            & (no_regs | latch_clr_ok(o));
        // Read latch loads on the memory enable
        if (read_latch_clear) begin
            port_step.latch = init;
        end else if (i.en) begin
            port_step.latch = i.mem_data;
        end
        // Primitive register follows the latch
        if (!o.prim_reg) begin
            port_step.prim = s.prim;
        end else if (output_register_clear) begin
            port_step.prim = init;
        end else if (i.regce) begin
            port_step.prim = s.latch;
        end
        // Core register follows primitive register or, without it, the latch
        if (!o.core_reg) begin
            port_step.core = s.core;
        end else if (output_register_clear) begin
            port_step.core = init;
        end else if (i.regce) begin
            port_step.core = o.prim_reg ? s.prim : s.latch;
        end
    endfunction

    // Status byte of one port
    function automatic logic [7:0] port_status(input mors_pkg::mors_opt_t o);
        port_status = 8'h00;
        port_status[mors_pkg::ST_LAT_LSB +: mors_pkg::LAT_W] = port_latency(o);
        port_status[mors_pkg::ST_LATCH_CLR] = latch_clr_ok(o);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    mors_pkg::mors_state_t st_r;   // Registered state
    mors_pkg::mors_state_t st_nxt; // Next state
    logic [31:0] cfg_word;         // Option register as read back
    logic [31:0] cfg_wr;           // Option register after byte-lane merge
    logic [31:0] status_word;      // Status register value
    logic setup;                   // APB setup cycle
    logic wr_access;               // APB write access phase
    logic hit_cfg;                 // Address decodes to the option register
    logic hit_status;              // Address decodes to the status register

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: APB slave and both read pipelines
    always_comb begin
        st_nxt = st_r;
        cfg_word = 32'h0000_0000;
        cfg_word[mors_pkg::PORT_A_LSB +: mors_pkg::OPT_W] = st_r.opt_a;
        cfg_word[mors_pkg::PORT_B_LSB +: mors_pkg::OPT_W] = st_r.opt_b;
        status_word = 32'h0000_0000;
        status_word[mors_pkg::ST_A_LSB +: 8] = port_status(st_r.opt_a);
        status_word[mors_pkg::ST_B_LSB +: 8] = port_status(st_r.opt_b);
        setup = psel & ~penable;
        wr_access = psel & penable & pwrite;
        hit_cfg = (paddr == mors_pkg::CFG_OFFSET);
        hit_status = (paddr == mors_pkg::STATUS_OFFSET);
        // Byte lanes merged into the current option word
        for (int b = 0; b < 4; b++) begin
            cfg_wr[b*8 +: 8] = pstrb[b] ? pwdata[b*8 +: 8] : cfg_word[b*8 +: 8];
        end
        // Read data and error captured in setup so access can finish at once
        if (setup) begin
            st_nxt.pslverr = ~(hit_cfg | hit_status) | (pwrite & hit_status);
            if (!pwrite && hit_cfg) begin
                st_nxt.prdata = cfg_word;
            end else if (!pwrite && hit_status) begin
                st_nxt.prdata = status_word;
            end else begin
                st_nxt.prdata = 32'h0000_0000;
            end
        end
        // Option write takes effect at the end of the access phase
        if (wr_access && hit_cfg) begin
            st_nxt.opt_a = cfg_wr[mors_pkg::PORT_A_LSB +: mors_pkg::OPT_W];
            st_nxt.opt_b = cfg_wr[mors_pkg::PORT_B_LSB +: mors_pkg::OPT_W];
        end
        // Each port runs on its own options
        st_nxt.pa = port_step(st_r.opt_a, port_a_in, st_r.pa, INIT_A);
        st_nxt.pb = port_step(st_r.opt_b, port_b_in, st_r.pb, INIT_B);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; data words restart at the port reset values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.opt_a <= mors_pkg::CFG_RESET;
            st_r.opt_b <= mors_pkg::CFG_RESET;
            st_r.pa <= {3{INIT_A}};
            st_r.pb <= {3{INIT_B}};
            st_r.prdata <= 32'h0000_0000;
            st_r.pslverr <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs; the slave never waits, so pready is tied high
    assign pready = 1'b1;
    assign prdata = st_r.prdata;
    assign pslverr = st_r.pslverr & psel & penable;
    assign dout_a = port_out(st_r.opt_a, st_r.pa);
    assign dout_b = port_out(st_r.opt_b, st_r.pb);

endmodule

/* testbench/mors_top_props.sv */
`timescale 1ns/1ps
module mors_top_props #(
    parameter logic [mors_pkg::DATA_W-1:0] INIT_A = 32'h0000_0000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [mors_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire mors_pkg::mors_port_in_t port_a_in,
    input wire logic [mors_pkg::DATA_W-1:0] dout_a
);
////////////////////////////////////////////////////////////////////////////////
logic [4:0] cfg_r; // Shadow of the port A options, so latency can be predicted
// Track option writes; the pipeline only sees them from the next cycle
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg_r <= 5'h00;
    else if (psel && penable && pwrite && paddr == mors_pkg::CFG_OFFSET && pstrb[0]) cfg_r <= pwdata[4:0];
end
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
////////////////////////////////////////////////////////////////////////////////
a_ready_high: assert property (pready) else $error("pready low");
a_bad_addr: assert property (psel && penable && !pwrite && paddr > 12'h004 |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
a_lat_none: assert property (cfg_r == 5'h00 && port_a_in.en |=> dout_a == $past(port_a_in.mem_data))
    else $error("unregistered latency wrong");
a_lat_prim: assert property (cfg_r == 5'h01 && port_a_in.en ##1 port_a_in.regce |=>
    dout_a == $past(port_a_in.mem_data, 2)) else $error("primitive stage latency wrong");
a_lat_core: assert property (cfg_r == 5'h02 && port_a_in.en ##1 port_a_in.regce |=>
    dout_a == $past(port_a_in.mem_data, 2)) else $error("core stage latency wrong");
a_lat_both: assert property (cfg_r == 5'h03 && port_a_in.en ##1 port_a_in.regce [*2] |=>
    dout_a == $past(port_a_in.mem_data, 3)) else $error("two stage latency wrong");
a_clr_two: assert property (cfg_r == 5'h1D && port_a_in.rst |=> dout_a == INIT_A ##1 dout_a == INIT_A)
    else $error("latch clear not held two cycles");
a_plain_rst: assert property (cfg_r == 5'h15 && port_a_in.rst |=> dout_a == INIT_A)
    else $error("output register not cleared");
c_both: cover property (cfg_r == 5'h03 && port_a_in.en);
c_clr: cover property (cfg_r == 5'h1D && port_a_in.rst);
c_err: cover property (pslverr);
endmodule
bind mors_top mors_top_props #(.INIT_A(INIT_A)) u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_a_in(port_a_in), .dout_a(dout_a));

/* testbench/mors_reader.sv */
`timescale 1ns/1ps
module mors_reader (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] lat,
    input wire logic en,
    input wire logic rst,
    input wire logic [31:0] din,
    output mors_pkg::mors_port_in_t port_in,
    output logic got
);
logic [2:0] sh_r; // Reads in flight, one bit per elapsed edge
// Output register enable held on; stalls are not part of this reader
assign port_in = '{en: en, regce: 1'b1, rst: rst, mem_data: din};
// A read cut by reset yields no data, so it is not tracked
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sh_r <= 3'h0;
    else sh_r <= {sh_r[1:0], en & ~rst};
end
assign got = (lat != 2'h0) && sh_r[lat-2'h1]; // Take data only once latency has run out
endmodule

/* testbench/mors_top_tb.sv */
`timescale 1ns/1ps
module mors_top_tb;
logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, got_a, got_b;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, prdata, rd, dout_a, dout_b, din_a = 32'h0, din_b = 32'h0, seed = 32'hFEECEDD9;
logic [1:0] en = 2'h0, rst = 2'h0, lat_a = 2'h1, lat_b = 2'h1;
logic [3:0] pstrb = 4'hF;
logic [31:0] q_a[$], q_b[$]; // Words expected on each port, oldest first
mors_pkg::mors_port_in_t pin_a, pin_b;
int fail_count = 0, tests_run = 0;
always #5 pclk = ~pclk;
////////////////////////////////////////////////////////////////////////////////
mors_top #(.INIT_A(32'hA5A5_5A5A), .INIT_B(32'h0F0F_F0F0)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_a_in(pin_a), .port_b_in(pin_b), .dout_a(dout_a), .dout_b(dout_b));
mors_reader u_rd_a (.pclk(pclk), .presetn(presetn), .lat(lat_a), .en(en[0]), .rst(rst[0]), .din(din_a),
    .port_in(pin_a), .got(got_a));
mors_reader u_rd_b (.pclk(pclk), .presetn(presetn), .lat(lat_b), .en(en[1]), .rst(rst[1]), .din(din_b),
    .port_in(pin_b), .got(got_b));
////////////////////////////////////////////////////////////////////////////////
function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
endfunction
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
        fail_count++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task automatic end_of_test;
    $display("mismatches=%0d comparisons=%0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
endtask
// One APB transfer; holds the request until pready is seen high, for at most 20 cycles
task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
        @(posedge pclk);
        n++;
    end while (pready !== 1'b1 && n < 20);
    // A slave that never answers counts as a mismatch rather than passing silently
    if (pready !== 1'b1) begin
        fail_count++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, pready, 1'b1);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
endtask
// Random reads on both ports at once, each noted before it is issued
task automatic stream(input int n);
    repeat (n) begin
        seed = lfsr(seed);
        en <= {seed[3], seed[0]};
        din_a <= seed;
        din_b <= ~seed;
        if (seed[0]) q_a.push_back(seed);
        if (seed[3]) q_b.push_back(~seed);
        @(posedge pclk);
    end
    en <= 2'h0;
    repeat (5) @(posedge pclk);
    chk(32'(q_a.size() + q_b.size()), 32'h0);
endtask
// Results are matched against the oldest note when the reader takes them
always @(posedge pclk) begin
    if (got_a) chk(dout_a, q_a.pop_front());
    if (got_b) chk(dout_b, q_b.pop_front());
end
initial begin
    #100000;
    fail_count++;
    end_of_test();
end
////////////////////////////////////////////////////////////////////////////////
initial begin
    logic [4:0] k;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, mors_pkg::CFG_OFFSET, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
        apb(1'b1, mors_pkg::CFG_OFFSET, {19'h0, 5'(3 - i), 3'h0, 5'(i)});
        lat_a <= 2'(1 + i[0] + i[1]);
        lat_b <= 2'(2 - i[0] - i[1] + 1);
        apb(1'b0, mors_pkg::STATUS_OFFSET, 32'h0);
        chk(rd, {22'h0, 2'(2 - i[0] - i[1] + 1), 6'h0, 2'(1 + i[0] + i[1])});
        stream(40);
    end
    apb(1'b1, mors_pkg::CFG_OFFSET, 32'h1B);
    apb(1'b0, mors_pkg::STATUS_OFFSET, 32'h0);
    chk(rd, 32'h0000_0103);
    lat_a <= 2'h2;
    for (int j = 0; j < 2; j++) begin
        k = j ? 5'h1D : 5'h15;
        apb(1'b1, mors_pkg::CFG_OFFSET, {27'h0, k});
        apb(1'b0, mors_pkg::STATUS_OFFSET, 32'h0);
        chk(rd, j ? 32'h0000_0106 : 32'h0000_0102);
        en <= 2'h1;
        din_a <= 32'hC0DE_1234;
        q_a.push_back(32'hC0DE_1234);
        @(posedge pclk);
        en <= 2'h0;
        repeat (3) @(posedge pclk);
        rst <= 2'h1;
        @(posedge pclk);
        rst <= 2'h0;
        repeat (3) @(posedge pclk);
        chk(dout_a, j ? 32'hA5A5_5A5A : 32'hC0DE_1234);
    end
    apb(1'b0, 12'h00C, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    apb(1'b1, mors_pkg::STATUS_OFFSET, 32'h0);
    chk({31'h0, err}, 32'h1);
    end_of_test();
end
endmodule
